// File: xdsd_core_model.sv
// xdsd_core_model: processor core issuing byte data moves
// assumes the decoder takes a request only while idle
`timescale 1ns/1ps
module xdsd_core_model (
  input wire logic clk,
  input wire logic done,
  input wire logic [7:0] rdata,
  output logic req,
  output logic wr,
  output logic wide,
  output logic [15:0] addr,
  output logic [7:0] wdata
);
  // quiet request lines at start
  initial begin
    req = 1'b0;
    wr = 1'b0;
    wide = 1'b0;
    addr = 16'h0000;
    wdata = 8'h00;
  end

  // one move: pulse, scramble released fields, wait for done
  task automatic mv(input logic w, input logic d16, input logic [15:0] a, input logic [7:0] v,
    output logic [7:0] r);
    @(posedge clk);
    req <= 1'b1;
    wr <= w;
    wide <= d16;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    req <= 1'b0;
    addr <= ~a;
    wdata <= ~v;
    while (done !== 1'b1) @(posedge clk);
    r = rdata;
  endtask : mv
endmodule : xdsd_core_model

// File: xdsd_nv_prog.sv
// xdsd_nv_prog: background erase-then-program timer for one nonvolatile byte
// assumes brownout is already synchronised to clk
`timescale 1ns/1ps
module xdsd_nv_prog #(
  parameter int ERASE_CYC = xdsd_pkg::NV_ERASE_CYC,
  parameter int PROG_CYC = xdsd_pkg::NV_PROG_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic start,
  input wire logic brownout,
  output logic busy,
  output logic erase,
  output logic prog_on,
  output logic fault
);

  localparam int CW = xdsd_pkg::CNT_W;

  // refuse counts the counter cannot hold
  if (ERASE_CYC < 1 || ERASE_CYC >= 2 ** CW || PROG_CYC < 1 || PROG_CYC >= 2 ** CW) begin : g_chk
    $error("xdsd_nv_prog: cycle count out of range");
  end

  typedef struct packed {
    xdsd_pkg::xdsd_phase_e phase;
    logic [CW-1:0] cnt;
    logic busy;
    logic erase;
    logic prog_on;
    logic fault;
  } xdsd_prog_s;

  xdsd_prog_s r;
  xdsd_prog_s n;

  // erase then program as one sequence, cut short only by brownout
  always_comb begin
    n = r;
    n.fault = 1'b0;
    case (r.phase)
      xdsd_pkg::PH_IDLE: begin
        if (start) begin
          n.phase = xdsd_pkg::PH_ERASE;
          n.cnt = CW'(ERASE_CYC - 1);
        end
      end
      xdsd_pkg::PH_ERASE: begin
        if (r.cnt == '0) begin
          n.phase = xdsd_pkg::PH_PROG;
          n.cnt = CW'(PROG_CYC - 1);
        end else begin
          n.cnt = r.cnt - 1'b1;
        end
      end
      xdsd_pkg::PH_PROG: begin
        if (r.cnt == '0) begin
          n.phase = xdsd_pkg::PH_IDLE;
        end else begin
          n.cnt = r.cnt - 1'b1;
        end
      end
      default: n.phase = xdsd_pkg::PH_IDLE;
    endcase
    // low supply aborts the write and reports it
    if (brownout && r.phase != xdsd_pkg::PH_IDLE) begin
      n.phase = xdsd_pkg::PH_IDLE;
      n.cnt = '0;
      n.fault = 1'b1;
    end
    n.busy = (n.phase != xdsd_pkg::PH_IDLE);
    n.erase = (n.phase == xdsd_pkg::PH_ERASE);
    n.prog_on = (n.phase == xdsd_pkg::PH_PROG);
  end

  // state register
  always_ff @(posedge clk) begin
    if (rst) begin
      r <= '0;
    end else if (ce) begin
      r <= n;
    end
  end

  assign busy = r.busy;
  assign erase = r.erase;
  assign prog_on = r.prog_on;
  assign fault = r.fault;

endmodule : xdsd_nv_prog

// File: xdsd_pkg.sv
// xdsd_pkg: shared constants and types of the external data space decoder
// assumes a 100 MHz system clock and a 12-bit APB byte address
package xdsd_pkg;

  // clock rate and derived cycle counts
  localparam int CLK_MHZ = 100;
  localparam int NV_ERASE_US = 1000;
  localparam int NV_PROG_US = 1000;
  localparam int BO_QUIET_US = 2000;
  localparam int NV_ERASE_CYC = NV_ERASE_US * CLK_MHZ;
  localparam int NV_PROG_CYC = NV_PROG_US * CLK_MHZ;
  localparam int BO_QUIET_CYC = BO_QUIET_US * CLK_MHZ;
  localparam int CNT_W = 20;

  // register indices and their byte addresses (index times four)
  localparam logic [7:0] PAGE_IDX = 8'hf6;
  localparam logic [7:0] AUX_IDX = 8'h8e;
  localparam logic [7:0] NVC_IDX = 8'hd2;
  localparam logic [11:0] PAGE_ADDR = {2'b00, PAGE_IDX, 2'b00};
  localparam logic [11:0] AUX_ADDR = {2'b00, AUX_IDX, 2'b00};
  localparam logic [11:0] NVC_ADDR = {2'b00, NVC_IDX, 2'b00};

  // values after reset
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [7:0] AUX_RST = 8'h08;

  // auxiliary control field positions
  localparam int AUX_AO = 0;
  localparam int AUX_EXT = 1;
  localparam int AUX_XRS = 2;
  localparam int AUX_WS0 = 5;
  localparam int AUX_WS1 = 6;

  // nonvolatile control field positions
  localparam int NVC_BUSY = 0;
  localparam int NVC_EEE = 1;
  localparam int NVC_ERR = 2;
  localparam int NVC_INH = 3;

  // address map limits
  localparam logic [7:0] PAGE_EXT_MIN = 8'h08;
  localparam logic [15:0] NV_TOP = 16'h0fff;
  localparam logic [7:0] NV_BLANK = 8'hff;

  // where a data move goes
  typedef enum logic [1:0] {TGT_RAM, TGT_NV, TGT_EXT} xdsd_tgt_e;

  // access sequencer states
  typedef enum logic [2:0] {ST_IDLE, ST_RAM, ST_NV_RD, ST_EXT} xdsd_state_e;

  // programming phases
  typedef enum logic [1:0] {PH_IDLE, PH_ERASE, PH_PROG} xdsd_phase_e;

endpackage : xdsd_pkg

// File: xdsd_props.sv
// xdsd_props: timing relations at the ports of the data space decoder
// assumes one clock domain and a synchronous active high reset
`timescale 1ns/1ps
module xdsd_props (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire logic CORE_DONE,
  input wire logic RAM_EN,
  input wire logic NV_RD,
  input wire logic NV_ERASE,
  input wire logic NV_PROGRAM,
  input wire logic EXT_REQ,
  input wire logic EXT_DONE,
  input wire logic [1:0] EXT_WAIT,
  input wire logic COMPAT_MODE,
  input wire logic BROWNOUT
);
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RST);

  // register bus answers after exactly one wait cycle
  apb_one_wait_a: assert property ($rose(PENABLE) && PSEL && CE |=> PREADY ##1 !PREADY)
    else $error("register bus ready timing wrong");
  // ram moves need two cycles, done is a single pulse
  ram_two_cycle_a: assert property (CE && RAM_EN |-> !CORE_DONE ##1 CORE_DONE)
    else $error("ram move finished too early or late");
  done_pulse_a: assert property (CORE_DONE |=> !CORE_DONE)
    else $error("move done held longer than one cycle");
  target_excl_a: assert property (RAM_EN |-> !NV_RD && !$rose(EXT_REQ))
    else $error("move sent to two targets");
  ext_release_a: assert property (CE && EXT_REQ && EXT_DONE |=> !EXT_REQ && CORE_DONE)
    else $error("external request not closed by its done");
  // compatibility mode clears the upper wait bit
  compat_ws_a: assert property ($past(COMPAT_MODE) && $past(CE) |-> !EXT_WAIT[1])
    else $error("upper wait bit active in compatibility mode");
  // erase strictly before program
  erase_excl_a: assert property (NV_ERASE |-> !NV_PROGRAM)
    else $error("erase and program overlap");
  prog_after_erase_a: assert property ($rose(NV_PROGRAM) |-> $past(NV_ERASE))
    else $error("program phase without erase before it");
  bo_abort_a: assert property ($rose(BROWNOUT) && (NV_ERASE || NV_PROGRAM) |-> ##[1:6] !(NV_ERASE || NV_PROGRAM))
    else $error("brownout did not stop programming");
  nv_rd_idle_a: assert property (NV_RD |-> !NV_ERASE && !NV_PROGRAM)
    else $error("nonvolatile read during programming");

  // main scenarios reached
  cover property (RAM_EN && CE);
  cover property ($rose(NV_PROGRAM));
  cover property (EXT_REQ && EXT_DONE);
endmodule : xdsd_props

bind xdsd_top xdsd_props u_props (.CLOCK, .RST, .CE, .PSEL, .PENABLE, .PREADY, .CORE_DONE, .RAM_EN, .NV_RD,
  .NV_ERASE, .NV_PROGRAM, .EXT_REQ, .EXT_DONE, .EXT_WAIT, .COMPAT_MODE, .BROWNOUT);

// File: xdsd_top.sv
// xdsd_top: external data space decoder with APB registers
// assumes core, RAM, nonvolatile array and external bus logic share CLOCK
//
// Functional notes
// - size field selects 256 to 2048 bytes of aux RAM; 11x reserved.
// - with external map off, moves inside aux RAM range hit internal RAM.
// - with external map on, every move goes to the external bus.
// - eight-bit moves take upper address from the page register.
// - one page value serves both eight-bit pointer registers.
// - page 08H to FFH sends eight-bit moves outside, page not driven high.
// - sixteen-bit moves reach aux RAM only with nonvolatile enable clear.
// - aux RAM moves take at least two clock cycles.
// - compatibility mode forces upper wait-state bit to zero.
// - external map off and enable set maps nonvolatile memory at 0000H-0FFFH.
// - enable clear makes nonvolatile memory unreachable.
// - eight-bit moves never reach nonvolatile memory.
// - with nonvolatile mapping, addresses above 0FFFH go external.
// - nonvolatile write runs in background; busy flag shows completion.
// - each byte write erases then programs, atomically.
// - no write starts if brown-out seen within last 2 ms.
// - brown-out during a write sets the error flag, bit 2.
// - busy flag bit 0 set while programming, blocks reads and writes.
// - latch idle bit: zero toggles strobe, one holds it weakly high.
//
// Local design decision: the APB register port.
`timescale 1ns/1ps
module xdsd_top #(
  parameter int NV_ERASE_CYC = xdsd_pkg::NV_ERASE_CYC,
  parameter int NV_PROG_CYC = xdsd_pkg::NV_PROG_CYC,
  parameter int BO_QUIET_CYC = xdsd_pkg::BO_QUIET_CYC
) (
  input wire logic CLOCK,
  input wire logic RST,
  input wire logic CE,
  // APB slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic PREADY,
  output logic [31:0] PRDATA,
  output logic PSLVERR,
  // core data move request
  input wire logic CORE_REQ,
  input wire logic CORE_WR,
  input wire logic CORE_WIDE,
  input wire logic [15:0] CORE_ADDR,
  input wire logic [7:0] CORE_WDATA,
  input wire logic COMPAT_MODE,
  output logic CORE_DONE,
  output logic [7:0] CORE_RDATA,
  // internal auxiliary RAM
  input wire logic [7:0] RAM_RDATA,
  output logic RAM_EN,
  output logic RAM_WE,
  output logic [10:0] RAM_ADDR,
  output logic [7:0] RAM_WDATA,
  // nonvolatile data memory
  input wire logic [7:0] NV_RDATA,
  input wire logic BROWNOUT,
  output logic NV_RD,
  output logic [11:0] NV_ADDR,
  output logic [7:0] NV_WDATA,
  output logic NV_ERASE,
  output logic NV_PROGRAM,
  // external memory bus
  input wire logic EXT_DONE,
  input wire logic [7:0] EXT_RDATA,
  output logic EXT_REQ,
  output logic EXT_WE,
  output logic [15:0] EXT_ADDR,
  output logic EXT_HI_DRIVE,
  output logic [7:0] EXT_WDATA,
  output logic [1:0] EXT_WAIT,
  output logic EXT_ALE_IDLE_HIGH
);

  localparam int CW = xdsd_pkg::CNT_W;
  localparam logic [CW-1:0] BO_TOP = CW'(BO_QUIET_CYC);

  // refuse a quiet window the counter cannot hold
  if (BO_QUIET_CYC < 1 || BO_QUIET_CYC >= 2 ** CW) begin : g_chk
    $error("xdsd_top: brown-out window out of range");
  end

  typedef struct packed {
    // software registers
    logic [7:0] page;
    logic [7:0] aux;
    logic eee;
    logic err;
    // brown-out synchroniser and quiet timer
    logic bo_meta;
    logic bo_sync;
    logic [CW-1:0] bo_cnt;
    // access sequencer
    xdsd_pkg::xdsd_state_e state;
    logic done;
    logic [7:0] rdata;
    logic [7:0] wdata;
    logic ram_en;
    logic ram_we;
    logic [10:0] ram_addr;
    logic nv_rd;
    logic nv_start;
    logic [11:0] nv_addr;
    logic [7:0] nv_wdata;
    logic ext_req;
    logic ext_we;
    logic [15:0] ext_addr;
    logic ext_hi;
    logic [1:0] ext_wait;
    // APB answer
    logic pready;
    logic [31:0] prdata;
    logic pslverr;
  } xdsd_top_s;

  xdsd_top_s r;
  xdsd_top_s n;

  logic nv_busy;
  logic nv_fault;
  logic nv_erase_q;
  logic nv_prog_q;

  // last enabled RAM page for a size code
  function automatic logic [2:0] last_page(input logic [2:0] aux_ram_size_field);
    case (aux_ram_size_field)
      3'b000: last_page = 3'd0;
      3'b001: last_page = 3'd1;
      3'b010: last_page = 3'd2;
      3'b011: last_page = 3'd3;
      3'b100: last_page = 3'd6;
      3'b101: last_page = 3'd7;
      default: last_page = 3'd2;
    endcase
  endfunction : last_page

  // decode of one data move against the current map
  function automatic xdsd_pkg::xdsd_tgt_e route(
    input logic wide,
    input logic [15:0] a,
    input logic [7:0] page,
    input logic [7:0] aux,
    input logic eee
  );
    logic [2:0] lp;
    lp = last_page(aux[xdsd_pkg::AUX_XRS +: 3]);
    if (aux[xdsd_pkg::AUX_EXT]) begin
      route = xdsd_pkg::TGT_EXT;
    end else if (wide && eee) begin
      if (a <= xdsd_pkg::NV_TOP) begin
        route = xdsd_pkg::TGT_NV;
      end else begin
        route = xdsd_pkg::TGT_EXT;
      end
    end else if (wide) begin
      if (a[15:11] == 5'b00000 && a[10:8] <= lp) begin
        route = xdsd_pkg::TGT_RAM;
      end else begin
        route = xdsd_pkg::TGT_EXT;
      end
    end else if (page >= xdsd_pkg::PAGE_EXT_MIN) begin
      route = xdsd_pkg::TGT_EXT;
    end else if (page[2:0] <= lp) begin
      route = xdsd_pkg::TGT_RAM;
    end else begin
      route = xdsd_pkg::TGT_EXT;
    end
  endfunction : route

  // background programming timer
  xdsd_nv_prog #(
    .ERASE_CYC(NV_ERASE_CYC),
    .PROG_CYC(NV_PROG_CYC)
  ) u_prog (
    .clk(CLOCK),
    .rst(RST),
    .ce(CE),
    .start(r.nv_start),
    .brownout(r.bo_sync),
    .busy(nv_busy),
    .erase(nv_erase_q),
    .prog_on(nv_prog_q),
    .fault(nv_fault)
  );

  // next-state logic of the whole block
  always_comb begin
    logic acc;
    logic hit;
    logic commit;
    logic blocked;
    logic quiet;
    logic [15:0] eff;
    xdsd_pkg::xdsd_tgt_e tgt;
    acc = 1'b0;
    hit = 1'b0;
    commit = 1'b0;
    blocked = 1'b0;
    quiet = 1'b0;
    eff = '0;
    tgt = xdsd_pkg::TGT_EXT;
    n = r;

    // brown-out level through two flops
    n.bo_meta = BROWNOUT;
    n.bo_sync = r.bo_meta;

    // time since brown-out last seen, counts from reset too
    if (r.bo_sync) begin
      n.bo_cnt = '0;
    end else if (r.bo_cnt != BO_TOP) begin
      n.bo_cnt = r.bo_cnt + 1'b1;
    end
    quiet = (r.bo_cnt == BO_TOP);

    // APB: answer in the second access cycle
    acc = PSEL && PENABLE;
    hit = (PADDR == xdsd_pkg::PAGE_ADDR) || (PADDR == xdsd_pkg::AUX_ADDR) ||
          (PADDR == xdsd_pkg::NVC_ADDR);
    n.pready = acc && !r.pready;
    n.pslverr = acc && !r.pready && !hit;
    n.prdata = '0;
    if (acc && !r.pready && !PWRITE) begin
      if (PADDR == xdsd_pkg::PAGE_ADDR) begin
        n.prdata = {24'h00_0000, r.page};
      end else if (PADDR == xdsd_pkg::AUX_ADDR) begin
        n.prdata = {24'h00_0000, r.aux};
      end else if (PADDR == xdsd_pkg::NVC_ADDR) begin
        n.prdata = {28'h000_0000, quiet, r.err, r.eee, nv_busy};
      end
    end
    commit = acc && r.pready && PWRITE && !r.pslverr;

    // register writes take effect at the completing edge
    if (commit && PADDR == xdsd_pkg::PAGE_ADDR) begin
      n.page = PWDATA[7:0];
    end
    if (commit && PADDR == xdsd_pkg::AUX_ADDR) begin
      n.aux = PWDATA[7:0];
      if (PWDATA[xdsd_pkg::AUX_XRS + 2 -: 2] == 2'b11) begin
        n.aux[xdsd_pkg::AUX_XRS +: 3] = r.aux[xdsd_pkg::AUX_XRS +: 3];
      end
    end
    if (commit && PADDR == xdsd_pkg::NVC_ADDR) begin
      n.eee = PWDATA[xdsd_pkg::NVC_EEE];
      n.err = PWDATA[xdsd_pkg::NVC_ERR];
    end
    // hardware set of the error flag wins over a clear
    if (nv_fault) begin
      n.err = 1'b1;
    end

    // wait states and latch idle control follow the register
    n.ext_wait = {r.aux[xdsd_pkg::AUX_WS1] && !COMPAT_MODE, r.aux[xdsd_pkg::AUX_WS0]};

    // one-cycle strobes fall by default
    n.done = 1'b0;
    n.nv_start = 1'b0;
    n.nv_rd = 1'b0;
    n.ram_en = 1'b0;
    n.ram_we = 1'b0;

    // eight-bit moves use the page register for the high byte
    eff = CORE_WIDE ? CORE_ADDR : {r.page, CORE_ADDR[7:0]};
    tgt = route(CORE_WIDE, CORE_ADDR, r.page, r.aux, r.eee);
    blocked = nv_busy || r.nv_start;

    // access sequencer
    case (r.state)
      xdsd_pkg::ST_IDLE: begin
        if (CORE_REQ) begin
          n.wdata = CORE_WDATA;
          case (tgt)
            xdsd_pkg::TGT_RAM: begin
              n.ram_en = 1'b1;
              n.ram_we = CORE_WR;
              n.ram_addr = eff[10:0];
              n.state = xdsd_pkg::ST_RAM;
            end
            xdsd_pkg::TGT_NV: begin
              n.nv_addr = blocked ? r.nv_addr : CORE_ADDR[11:0]; // write in flight keeps its byte
              if (blocked) begin
                n.rdata = xdsd_pkg::NV_BLANK;
                n.done = 1'b1;
              end else if (CORE_WR) begin
                n.nv_wdata = CORE_WDATA; // held through erase and program
                n.nv_start = quiet;
                n.done = 1'b1;
              end else begin
                n.nv_rd = 1'b1;
                n.state = xdsd_pkg::ST_NV_RD;
              end
            end
            default: begin
              n.ext_req = 1'b1;
              n.ext_we = CORE_WR;
              n.ext_addr = eff;
              n.ext_hi = CORE_WIDE || r.page < xdsd_pkg::PAGE_EXT_MIN;
              n.state = xdsd_pkg::ST_EXT;
            end
          endcase
        end
      end
      xdsd_pkg::ST_RAM: begin
        n.rdata = RAM_RDATA;
        n.done = 1'b1;
        n.state = xdsd_pkg::ST_IDLE;
      end
      xdsd_pkg::ST_NV_RD: begin
        n.rdata = NV_RDATA;
        n.done = 1'b1;
        n.state = xdsd_pkg::ST_IDLE;
      end
      xdsd_pkg::ST_EXT: begin
        if (EXT_DONE) begin
          n.rdata = EXT_RDATA;
          n.ext_req = 1'b0;
          n.done = 1'b1;
          n.state = xdsd_pkg::ST_IDLE;
        end
      end
      default: n.state = xdsd_pkg::ST_IDLE;
    endcase
  end

  // single state register, frozen while CE is low
  always_ff @(posedge CLOCK) begin
    if (RST) begin
      r <= '0;
      r.page <= xdsd_pkg::PAGE_RST;
      r.aux <= xdsd_pkg::AUX_RST;
    end else if (CE) begin
      r <= n;
    end
  end

  // APB outputs
  assign PREADY = r.pready;
  assign PRDATA = r.prdata;
  assign PSLVERR = r.pslverr;

  // core answer
  assign CORE_DONE = r.done;
  assign CORE_RDATA = r.rdata;

  // RAM port
  assign RAM_EN = r.ram_en;
  assign RAM_WE = r.ram_we;
  assign RAM_ADDR = r.ram_addr;
  assign RAM_WDATA = r.wdata;
  // nonvolatile port
  assign NV_RD = r.nv_rd;
  assign NV_ADDR = r.nv_addr;
  assign NV_WDATA = r.nv_wdata;
  assign NV_ERASE = nv_erase_q;
  assign NV_PROGRAM = nv_prog_q;
  // external bus port
  assign EXT_REQ = r.ext_req;
  assign EXT_WE = r.ext_we;
  assign EXT_ADDR = r.ext_addr;
  assign EXT_HI_DRIVE = r.ext_hi;
  assign EXT_WDATA = r.wdata;
  assign EXT_WAIT = r.ext_wait;
  assign EXT_ALE_IDLE_HIGH = r.aux[xdsd_pkg::AUX_AO];

endmodule : xdsd_top

// File: xdsd_top_test.sv
// xdsd_top_test: register, routing and programming scenarios
// assumes core model and checker compiled before this file
`timescale 1ns/1ps
module xdsd_top_test;
  localparam logic [11:0] a_page = xdsd_pkg::PAGE_ADDR;
  localparam logic [11:0] a_aux = xdsd_pkg::AUX_ADDR;
  localparam logic [11:0] a_nvc = xdsd_pkg::NVC_ADDR;
  logic CLOCK, RST, CE, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, COMPAT_MODE, BROWNOUT, EXT_DONE, EXT_REQ;
  logic CORE_REQ, CORE_WR, CORE_WIDE, CORE_DONE, RAM_EN, RAM_WE, NV_RD, NV_ERASE, NV_PROGRAM, EXT_HI_DRIVE;
  logic EXT_ALE_IDLE_HIGH, EXT_WE, serr, hi_q;
  logic [11:0] PADDR, NV_ADDR;
  logic [31:0] PWDATA, PRDATA, rv;
  logic [15:0] CORE_ADDR, EXT_ADDR;
  logic [10:0] RAM_ADDR;
  logic [7:0] CORE_WDATA, CORE_RDATA, RAM_RDATA, RAM_WDATA, NV_RDATA, NV_WDATA, EXT_RDATA, EXT_WDATA, r8;
  logic [7:0] ram [2048];
  logic [7:0] nv [4096];
  logic [15:0] sz [6] = '{16'h0100, 16'h0200, 16'h0300, 16'h0400, 16'h0700, 16'h0800};
  logic [1:0] EXT_WAIT, ecnt;
  logic [8:0] ew_q;
  int failures = 0;
  int check_count = 0;
  int cyc = 0;

  xdsd_top #(.NV_ERASE_CYC(20), .NV_PROG_CYC(20), .BO_QUIET_CYC(50)) uut (.CLOCK, .RST, .CE, .PSEL, .PENABLE,
    .PWRITE, .PADDR, .PWDATA, .PREADY, .PRDATA, .PSLVERR, .CORE_REQ, .CORE_WR, .CORE_WIDE, .CORE_ADDR,
    .CORE_WDATA, .COMPAT_MODE, .CORE_DONE, .CORE_RDATA, .RAM_RDATA, .RAM_EN, .RAM_WE, .RAM_ADDR, .RAM_WDATA,
    .NV_RDATA, .BROWNOUT, .NV_RD, .NV_ADDR, .NV_WDATA, .NV_ERASE, .NV_PROGRAM, .EXT_DONE, .EXT_RDATA,
    .EXT_REQ, .EXT_WE, .EXT_ADDR, .EXT_HI_DRIVE, .EXT_WDATA, .EXT_WAIT, .EXT_ALE_IDLE_HIGH);
  xdsd_core_model core (.clk(CLOCK), .done(CORE_DONE), .rdata(CORE_RDATA), .req(CORE_REQ), .wr(CORE_WR),
    .wide(CORE_WIDE), .addr(CORE_ADDR), .wdata(CORE_WDATA));

  // arrays read through: data stands in the cycle the decoder raises its read enable
  assign RAM_RDATA = RAM_EN ? ram[RAM_ADDR] : 8'h00;
  assign NV_RDATA = NV_RD ? nv[NV_ADDR] : 8'h00;

  // clock
  initial begin
    CLOCK = 1'b0;
    forever #5 CLOCK = ~CLOCK;
  end

  // memories and external bus, scrambled when not answering
  always @(posedge CLOCK) begin
    cyc <= cyc + 1;
    if (RAM_EN && RAM_WE) ram[RAM_ADDR] <= RAM_WDATA;
    if (NV_ERASE) nv[NV_ADDR] <= 8'hff;
    else if (NV_PROGRAM) nv[NV_ADDR] <= NV_WDATA;
    ecnt <= (EXT_REQ && !EXT_DONE) ? ecnt + 2'h1 : 2'h0;
    EXT_DONE <= EXT_REQ && !EXT_DONE && ecnt == 2'h2;
    EXT_RDATA <= (EXT_REQ && !EXT_DONE && ecnt == 2'h2) ? EXT_ADDR[7:0] ^ 8'h5a : ~EXT_RDATA;
    if (EXT_DONE) hi_q <= EXT_HI_DRIVE;
    if (EXT_DONE) ew_q <= {EXT_WE, EXT_WDATA};
    if (cyc == 20000) begin
      failures++;
      final_report();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one register bus transfer, held until ready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge CLOCK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLOCK);
    PENABLE <= 1'b1;
    do @(posedge CLOCK); while (PREADY !== 1'b1);
    rv = PRDATA;
    serr = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask : apb

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rd(input logic [11:0] a);
    apb(1'b0, a, 32'h0000_0000);
  endtask : rd

  task automatic poll(input int b, input logic v);
    do rd(a_nvc); while (rv[b] !== v);
  endtask : poll

  task automatic mv(input logic w, input logic d16, input logic [15:0] a, input logic [7:0] d);
    core.mv(w, d16, a, d, r8);
  endtask : mv

  task automatic mvc(input logic d16, input logic [15:0] a, input logic [7:0] e);
    core.mv(1'b0, d16, a, 8'h00, r8);
    chk({24'h0, r8}, {24'h0, e});
  endtask : mvc

  task final_report;
    $display("checks=%0d failures=%0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report

  // main sequence
  initial begin
    RST = 1'b1;
    CE = 1'b1;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h0000_0000;
    COMPAT_MODE = 1'b0;
    BROWNOUT = 1'b0;
    EXT_DONE = 1'b0;
    EXT_RDATA = 8'h00;
    ecnt = 2'h0;
    hi_q = 1'b0;
    ew_q = 9'h000;
    repeat (10) @(posedge CLOCK);
    RST <= 1'b0;
    rd(a_page);
    chk(rv, 32'h0000_0000);
    rd(a_aux);
    chk(rv, 32'h0000_0008);
    rd(12'h000);
    chk({31'h0, serr}, 32'h0000_0001);
    wr(a_aux, 32'h0000_0018);
    rd(a_aux);
    chk(rv, 32'h0000_0008);
    for (int i = 0; i < 6; i++) begin
      wr(a_aux, {27'h0, i[2:0], 2'h0});
      mv(1'b1, 1'b1, sz[i] - 16'h0001, 8'h30 + 8'(i));
      mvc(1'b1, sz[i] - 16'h0001, 8'h30 + 8'(i));
      mvc(1'b1, sz[i], 8'h5a);
    end
    $display("test ram size done");
    wr(a_aux, 32'h0000_0008);
    mv(1'b1, 1'b1, 16'h0010, 8'ha5);
    wr(a_aux, 32'h0000_000a);
    mv(1'b1, 1'b1, 16'h0044, 8'hc3);
    chk({23'h0, ew_q}, 32'h0000_01c3);
    mvc(1'b1, 16'h0010, 8'h4a);
    mvc(1'b1, 16'hfff0, 8'haa);
    chk({31'h0, hi_q}, 32'h0000_0001);
    wr(a_aux, 32'h0000_0008);
    mvc(1'b1, 16'h0010, 8'ha5);
    $display("test external map done");
    wr(a_aux, 32'h0000_0014);
    wr(a_page, 32'h0000_0003);
    mv(1'b1, 1'b0, 16'h0022, 8'h77);
    mvc(1'b1, 16'h0322, 8'h77);
    wr(a_page, 32'h0000_0008);
    mvc(1'b0, 16'h0022, 8'h78);
    chk({31'h0, hi_q}, 32'h0000_0000);
    wr(a_page, 32'h0000_0003);
    $display("test paging done");
    poll(3, 1'b1);
    wr(a_nvc, 32'h0000_0002);
    mv(1'b1, 1'b1, 16'h0322, 8'h9c);
    rd(a_nvc);
    chk(rv, 32'h0000_000b);
    mvc(1'b1, 16'h0322, 8'hff);
    mvc(1'b0, 16'h0022, 8'h77);
    poll(0, 1'b0);
    mvc(1'b1, 16'h0322, 8'h9c);
    mvc(1'b1, 16'h1000, 8'h5a);
    wr(a_nvc, 32'h0000_0000);
    mvc(1'b1, 16'h0322, 8'h77);
    $display("test nonvolatile done");
    wr(a_nvc, 32'h0000_0002);
    mv(1'b1, 1'b1, 16'h0322, 8'h11);
    while (NV_ERASE !== 1'b1) @(posedge CLOCK);
    BROWNOUT <= 1'b1;
    repeat (6) @(posedge CLOCK);
    BROWNOUT <= 1'b0;
    rd(a_nvc);
    chk(rv, 32'h0000_0006);
    mv(1'b1, 1'b1, 16'h0322, 8'h22);
    repeat (4) @(posedge CLOCK);
    chk({31'h0, NV_ERASE}, 32'h0000_0000);
    poll(3, 1'b1);
    wr(a_nvc, 32'h0000_0000);
    rd(a_nvc);
    chk(rv, 32'h0000_0008);
    $display("test brownout done");
    wr(a_aux, 32'h0000_0069);
    repeat (2) @(posedge CLOCK);
    chk({29'h0, EXT_WAIT, EXT_ALE_IDLE_HIGH}, 32'h0000_0007);
    COMPAT_MODE <= 1'b1;
    repeat (2) @(posedge CLOCK);
    chk({30'h0, EXT_WAIT}, 32'h0000_0001);
    CE <= 1'b0;
    COMPAT_MODE <= 1'b0;
    repeat (3) @(posedge CLOCK);
    chk({30'h0, EXT_WAIT}, 32'h0000_0001);
    CE <= 1'b1;
    repeat (2) @(posedge CLOCK);
    chk({30'h0, EXT_WAIT}, 32'h0000_0003);
    $display("test wait bits done");
    final_report();
  end
endmodule : xdsd_top_test
